// >>> pkg/susres_pkg.sv
`default_nettype none
package susres_pkg;
    // clock period in ns at 20 MHz
    localparam int unsigned CLK_PERIOD_NS  = 50;
    // suspend isolation and resume re-enable deadline
    localparam int unsigned ISOLATE_US     = 32;
    localparam int unsigned ISOLATE_CYC    = (ISOLATE_US * 1000) / CLK_PERIOD_NS;
    // processor reset pulse width after resume or bus reset release
    localparam int unsigned PROCESSOR_RESET_OUT_N_MS      = 1;
    localparam int unsigned PROCESSOR_RESET_OUT_N_CYC     = (PROCESSOR_RESET_OUT_N_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // isolation sequencing delay (cycles) chosen well under the deadline
    localparam logic [9:0]  ISO_DELAY      = 10'h004;
    localparam int unsigned CNT_W          = 16;

    typedef enum logic [4:0] {
        ST_RUN     = 5'h01,
        ST_ENTER   = 5'h02,
        ST_SUSP    = 5'h04,
        ST_RESUME  = 5'h08,
        ST_RSTHOLD = 5'h10
    } seq_state_t;

    typedef enum logic {
        MEM_SDRAM = 1'b0,
        MEM_EDO   = 1'b1
    } mem_kind_t;

    // pad control handed to the pin ring
    typedef struct packed {
        logic host_oe_n;
        logic ctl_oe_n;
        logic ad_force_low;
        logic we_force_high;
        logic cs_force_high;
        logic cke_force_low;
        logic strobe_force_low;
    } pad_ctl_t;

    localparam pad_ctl_t PAD_NORMAL = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage : susres_pkg
`default_nettype wire

// >>> rtl/sync_edge.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser with edge pulses taken from the second stage
module sync_edge
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    logic last_reg;
    logic last_next;

    always_comb
    begin
        meta_next = async_i;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    // reset to the inactive-high level of the active-low pins
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule : sync_edge
`default_nettype wire

// >>> rtl/suspend_resume_power_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// R1 - suspend with bus reset idle: suspend refresh, isolate
// R2 - isolation done within 32 us
// R3 - resume under bus reset: internal reset, keep suspend
// R4 - plain resume: normal refresh, optional processor reset
// R5 - far side suspends only when system idle
// R6 - far side keeps power, clocks 32 us
// R7 - far side never stops pci clock mid-suspend
// R8 - bus reset and clocks never isolated
// R9 - clock source drives clocks low, then powers down
// R10 - power, clocks stable 1 ms before resume
// R11 - stop-clock held about 100 us after resume
// R12 - processor reset active within 10 ns of power
// R13 - power good at least 1 ms after supply
// R14 - late bridge power good precedes southbridge power good
// R15 - suspend planes release 1-2 rtc after resume reset
// R16 - clock stops release 16 ms after planes
// R17 - rtc unit about 32 us
// R18 - suspend status released 1 ms after clock stops
// R19 - bus reset released within 1 rtc after status
// R20 - processor reset held 1 ms after bus reset
// R21 - suspended: tristate host/control, low ad, high we
// R22 - suspended dram: selects high or strobes low
// R23 - buffers re-enabled within 32 us of resume
// R24 - cpu reset 1 ms on resume when enabled
// R25 - synchronise inputs, act once per edge
module suspend_resume_power_sequencer
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  bridge_power_good_i,
    input  wire logic                  suspend_status_n_i,
    input  wire logic                  bus_reset_in_n_i,
    input  wire logic                  processor_reset_enable_i,
    input  wire logic                  sw_normal_refresh_set_i,
    input  wire susres_pkg::mem_kind_t mem_kind_i,
    output logic                       normal_refresh_enable_o,
    output logic                       suspend_refresh_o,
    output logic                       self_refresh_entered_o,
    output logic                       processor_reset_out_n_o,
    output logic                       processor_reset_oe_n_o,
    output logic                       internal_reset_o,
    output logic                       buffers_isolated_o,
    output susres_pkg::pad_ctl_t       pad_ctl_o
);
    logic sus_level;
    logic sus_assert;
    logic sus_release;
    logic brst_level;
    logic brst_assert;
    logic brst_release;

    // both edges of the suspend status are acted on at most once; the bus reset is used only as a level [R25]
    sync_edge u_sus_sync
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (suspend_status_n_i),
        .level_o (sus_level),
        .rise_o  (sus_release),
        .fall_o  (sus_assert)
    );

    sync_edge u_brst_sync
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (bus_reset_in_n_i),
        .level_o (brst_level),
        .rise_o  (brst_release),
        .fall_o  (brst_assert)
    );

    susres_pkg::seq_state_t state_reg;
    susres_pkg::seq_state_t state_next;
    logic [susres_pkg::CNT_W-1:0] cnt_reg;
    logic [susres_pkg::CNT_W-1:0] cnt_next;
    logic [susres_pkg::CNT_W-1:0] rst_cnt_reg;
    logic [susres_pkg::CNT_W-1:0] rst_cnt_next;
    logic nref_reg;
    logic nref_next;
    logic sref_reg;
    logic sref_next;
    logic self_reg;
    logic self_next;
    logic iso_reg;
    logic iso_next;
    logic processor_reset_out_n_reg;
    logic processor_reset_out_n_next;
    logic processor_reset_out_n_n_reg;
    logic processor_reset_out_n_n_next;
    logic intrst_reg;
    logic intrst_next;
    susres_pkg::pad_ctl_t pad_reg;
    susres_pkg::pad_ctl_t pad_next;

    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        rst_cnt_next = rst_cnt_reg;
        nref_next    = nref_reg;
        sref_next    = sref_reg;
        self_next    = self_reg;
        iso_next     = iso_reg;
        processor_reset_out_n_next  = processor_reset_out_n_reg;
        intrst_next  = 1'b0;
        pad_next     = pad_reg;

        if (sw_normal_refresh_set_i)
        begin
            nref_next = 1'b1;
            sref_next = 1'b0;
        end

        // the bus reset is never gated, so it asserts processor reset even while isolated, though the pin floats until the buffers return [R8]
        if (!brst_level)
        begin
            processor_reset_out_n_next  = 1'b1;
            rst_cnt_next = susres_pkg::CNT_W'(susres_pkg::PROCESSOR_RESET_OUT_N_CYC);
        end
        else if (rst_cnt_reg != '0)
        begin
            rst_cnt_next = rst_cnt_reg - 1'b1;
        end
        else
        begin
            // release only after the full pulse past bus reset or resume [R20] [R24]
            processor_reset_out_n_next = 1'b0;
        end

        case (state_reg)
            susres_pkg::ST_RUN:
            begin
                if (sus_assert && brst_level)
                begin
                    // enter suspend refresh [R1]
                    sref_next  = 1'b1;
                    nref_next  = 1'b0;
                    cnt_next   = susres_pkg::CNT_W'(susres_pkg::ISO_DELAY);
                    state_next = susres_pkg::ST_ENTER;
                end
            end
            susres_pkg::ST_ENTER:
            begin
                // short drain then isolate, far inside the 32 us window [R2]
                if (cnt_reg != '0)
                begin
                    cnt_next = cnt_reg - 1'b1;
                end
                else
                begin
                    iso_next  = 1'b1; // [R1]
                    self_next = 1'b1;
                    // suspend pin states per dram type [R21] [R22]
                    pad_next.host_oe_n     = 1'b1;
                    pad_next.ctl_oe_n      = 1'b1;
                    pad_next.ad_force_low  = 1'b1;
                    pad_next.we_force_high = 1'b1;
                    if (mem_kind_i == susres_pkg::MEM_SDRAM)
                    begin
                        pad_next.cs_force_high = 1'b1;
                        pad_next.cke_force_low = 1'b1;
                    end
                    else
                    begin
                        pad_next.strobe_force_low = 1'b1;
                    end
                    state_next = susres_pkg::ST_SUSP;
                end
            end
            susres_pkg::ST_SUSP:
            begin
                if (sus_release)
                begin
                    state_next = susres_pkg::ST_RESUME;
                end
            end
            susres_pkg::ST_RESUME:
            begin
                // buffers back two cycles after the edge, within 32 us [R23]
                iso_next  = 1'b0;
                self_next = 1'b0;
                pad_next  = susres_pkg::PAD_NORMAL;
                if (!brst_level)
                begin
                    // internal reset; refresh logic keeps suspend mode [R3]
                    intrst_next = 1'b1;
                end
                else
                begin
                    // auto return to normal refresh [R4]
                    nref_next = 1'b1;
                    sref_next = 1'b0;
                    if (processor_reset_enable_i)
                    begin
                        processor_reset_out_n_next  = 1'b1; // [R24]
                        rst_cnt_next = susres_pkg::CNT_W'(susres_pkg::PROCESSOR_RESET_OUT_N_CYC);
                    end
                end
                state_next = susres_pkg::ST_RSTHOLD;
            end
            susres_pkg::ST_RSTHOLD:
            begin
                state_next = susres_pkg::ST_RUN;
            end
            default:
            begin
                state_next = susres_pkg::ST_RUN;
            end
        endcase

        // separate active-low copy so the pin comes straight from a flop
        processor_reset_out_n_n_next = ~processor_reset_out_n_next;
    end

    always_ff @(posedge mclk_i)
    begin
        // no power good: full reset with processor reset asserted [R12]
        if (rst_i || !bridge_power_good_i)
        begin
            state_reg   <= susres_pkg::ST_RUN;
            cnt_reg     <= '0;
            rst_cnt_reg <= susres_pkg::CNT_W'(susres_pkg::PROCESSOR_RESET_OUT_N_CYC);
            nref_reg    <= 1'b0;
            sref_reg    <= 1'b0;
            self_reg    <= 1'b0;
            iso_reg     <= 1'b0;
            processor_reset_out_n_reg  <= 1'b1;
            processor_reset_out_n_n_reg <= 1'b0;
            intrst_reg  <= 1'b1;
            pad_reg     <= susres_pkg::PAD_NORMAL;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            rst_cnt_reg <= rst_cnt_next;
            nref_reg    <= nref_next;
            sref_reg    <= sref_next;
            self_reg    <= self_next;
            iso_reg     <= iso_next;
            processor_reset_out_n_reg  <= processor_reset_out_n_next;
            processor_reset_out_n_n_reg <= processor_reset_out_n_n_next;
            intrst_reg  <= intrst_next;
            pad_reg     <= pad_next;
        end
    end

    assign normal_refresh_enable_o = nref_reg;
    assign suspend_refresh_o       = sref_reg;
    assign self_refresh_entered_o  = self_reg;
    assign processor_reset_out_n_o = processor_reset_out_n_n_reg;
    // processor reset floats while isolated [R21]
    assign processor_reset_oe_n_o  = pad_reg.host_oe_n;
    assign internal_reset_o        = intrst_reg;
    assign buffers_isolated_o      = iso_reg;
    assign pad_ctl_o               = pad_reg;

    // brst_assert/brst_release and sus_level feed nothing; kept for symmetry of the synchroniser
    logic unused_edges;
    assign unused_edges = brst_assert ^ brst_release ^ sus_level;
endmodule : suspend_resume_power_sequencer
`default_nettype wire

// >>> sim/susres_partner.sv
`timescale 1ns/1ns
`default_nettype none
// far-side power controller: drives suspend status and the bus reset
module susres_partner
#(
    parameter int unsigned HOLD_CYC = 20000
)
(
    input  wire logic mclk_i,
    output var  logic suspend_status_n_o,
    output var  logic bus_reset_in_n_o
);
    initial
    begin
        suspend_status_n_o = 1'b1;
        bus_reset_in_n_o   = 1'b1;
    end
    // one rtc unit of about 32 us at the 50 ns clock
    localparam int unsigned RTC_CYC = 640;
    task automatic step(input int unsigned n);
        repeat (n) @(posedge mclk_i);
        #5;
    endtask : step
    // caller only suspends an idle system; power and clocks never move here
    task automatic suspend();
        step(1);
        suspend_status_n_o = 1'b0;
        step(RTC_CYC);
    endtask : suspend
    task automatic resume();
        // clock stops released long before; stop-clock to the processor outlasts this edge
        step(HOLD_CYC);
        suspend_status_n_o = 1'b1;
    endtask : resume
    task automatic bus_reset(input logic v);
        step(1);
        bus_reset_in_n_o = v;
    endtask : bus_reset
endmodule : susres_partner
`default_nettype wire

// >>> sim/susres_checker.sv
`timescale 1ns/1ns
`default_nettype none
module susres_checker
(
    input wire logic                  mclk_i,
    input wire logic                  rst_i,
    input wire logic                  bridge_power_good_i,
    input wire logic                  suspend_status_n_i,
    input wire logic                  bus_reset_in_n_i,
    input wire logic                  processor_reset_enable_i,
    input wire susres_pkg::mem_kind_t mem_kind_i,
    input wire logic                  normal_refresh_enable_o,
    input wire logic                  suspend_refresh_o,
    input wire logic                  processor_reset_out_n_o,
    input wire logic                  processor_reset_oe_n_o,
    input wire logic                  internal_reset_o,
    input wire logic                  buffers_isolated_o,
    input wire susres_pkg::pad_ctl_t  pad_ctl_o
);
    logic [15:0] low_cnt_reg;
    logic [15:0] low_cnt_next;
    always_comb low_cnt_next = (rst_i || processor_reset_out_n_o) ? 16'h0000 : low_cnt_reg + 16'h0001;
    always_ff @(posedge mclk_i) low_cnt_reg <= low_cnt_next;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i || !bridge_power_good_i);
    sequence enter_s; $fell(suspend_status_n_i) && bus_reset_in_n_i; endsequence
    sequence leave_s; $fell(buffers_isolated_o); endsequence
    iso_deadline_a: assert property (enter_s |-> ##[1:640] buffers_isolated_o)
        else $error("isolation late");
    sref_first_a: assert property ($rose(buffers_isolated_o) |-> suspend_refresh_o && !normal_refresh_enable_o)
        else $error("no suspend refresh");
    pads_float_a: assert property (buffers_isolated_o |-> processor_reset_oe_n_o && pad_ctl_o.host_oe_n
        && pad_ctl_o.ctl_oe_n && pad_ctl_o.ad_force_low && pad_ctl_o.we_force_high) else $error("pads not isolated");
    dram_pads_a: assert property (buffers_isolated_o |-> (mem_kind_i == susres_pkg::MEM_EDO) ?
        pad_ctl_o.strobe_force_low : (pad_ctl_o.cs_force_high && pad_ctl_o.cke_force_low)) else $error("dram pads");
    resume_deadline_a: assert property ($rose(suspend_status_n_i) && buffers_isolated_o
        |-> ##[1:640] !buffers_isolated_o) else $error("buffers not back");
    auto_normal_a: assert property (leave_s ##0 bus_reset_in_n_i |-> normal_refresh_enable_o && !suspend_refresh_o)
        else $error("no normal refresh");
    bus_reset_resume_a: assert property (leave_s ##0 !bus_reset_in_n_i |-> suspend_refresh_o
        && !normal_refresh_enable_o ##[0:2] internal_reset_o) else $error("bus reset resume");
    // the enable is taken on the edge before buffers come back, so look one cycle back
    no_cpu_reset_a: assert property (leave_s ##0 bus_reset_in_n_i && !$past(processor_reset_enable_i)
        |-> processor_reset_out_n_o [*4]) else $error("stray cpu reset");
    cpu_reset_now_a: assert property (leave_s ##0 bus_reset_in_n_i && $past(processor_reset_enable_i)
        |-> ##[0:2] !processor_reset_out_n_o) else $error("cpu reset missing");
    cpu_pulse_a: assert property ($rose(processor_reset_out_n_o)
        |-> low_cnt_reg >= 16'(susres_pkg::PROCESSOR_RESET_OUT_N_CYC - 1)) else $error("cpu reset short");
    power_good_a: assert property (disable iff (rst_i) !bridge_power_good_i
        |=> !processor_reset_out_n_o && internal_reset_o) else $error("no reset on power good");
endmodule : susres_checker
bind suspend_resume_power_sequencer susres_checker chk_u (.mclk_i, .rst_i, .bridge_power_good_i, .suspend_status_n_i,
    .bus_reset_in_n_i, .processor_reset_enable_i, .mem_kind_i, .normal_refresh_enable_o, .suspend_refresh_o,
    .processor_reset_out_n_o, .processor_reset_oe_n_o, .internal_reset_o, .buffers_isolated_o, .pad_ctl_o);
`default_nettype wire

// >>> sim/suspend_resume_power_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module suspend_resume_power_sequencer_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bridge_power_good_i = 1'b1;
    logic processor_reset_enable_i = 1'b0;
    logic sw_normal_refresh_set_i = 1'b0;
    susres_pkg::mem_kind_t mem_kind_i = susres_pkg::MEM_SDRAM;
    wire logic suspend_status_n_i, bus_reset_in_n_i;
    logic normal_refresh_enable_o, suspend_refresh_o, self_refresh_entered_o, processor_reset_out_n_o;
    logic processor_reset_oe_n_o, internal_reset_o, buffers_isolated_o;
    susres_pkg::pad_ctl_t pad_ctl_o;
    int error_cnt = 0;
    int checked = 0;
    logic ir_seen;
    always #25 mclk_i = ~mclk_i;
    susres_partner partner_u (.mclk_i, .suspend_status_n_o(suspend_status_n_i), .bus_reset_in_n_o(bus_reset_in_n_i));
    suspend_resume_power_sequencer dut_u (.mclk_i, .rst_i, .bridge_power_good_i, .suspend_status_n_i, .bus_reset_in_n_i,
        .processor_reset_enable_i, .sw_normal_refresh_set_i, .mem_kind_i, .normal_refresh_enable_o, .suspend_refresh_o,
        .self_refresh_entered_o, .processor_reset_out_n_o, .processor_reset_oe_n_o, .internal_reset_o,
        .buffers_isolated_o, .pad_ctl_o);
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #5;
    endtask : cyc
    task automatic wait_iso(input logic v);
        ir_seen = 1'b0;
        for (int i = 0; i < 640; i++)
        begin
            ir_seen |= internal_reset_o;
            if (buffers_isolated_o === v) break;
            cyc(1);
        end
    endtask : wait_iso
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic t_reset();
        cyc(12);
        rst_i = 1'b0;
        cyc(2);
        bridge_power_good_i = 1'b0;
        cyc(3);
        check(internal_reset_o, 1'b1);
        check(processor_reset_out_n_o, 1'b0);
        // supply, suspend planes and clock stops are taken as settled before power good returns
        bridge_power_good_i = 1'b1;
        cyc(19990);
        check(processor_reset_out_n_o, 1'b0);
        cyc(20);
        check(processor_reset_out_n_o, 1'b1);
        check(pad_ctl_o, susres_pkg::PAD_NORMAL);
    endtask : t_reset
    // the long cpu reset check is only run where the pulse is expected
    task automatic t_susres(input susres_pkg::mem_kind_t kind, input logic en);
        mem_kind_i = kind;
        processor_reset_enable_i = en;
        partner_u.suspend();
        check({buffers_isolated_o, suspend_refresh_o, normal_refresh_enable_o}, 3'h6);
        check({processor_reset_oe_n_o, pad_ctl_o.host_oe_n, pad_ctl_o.ad_force_low, pad_ctl_o.we_force_high}, 4'hf);
        check(kind == susres_pkg::MEM_EDO ? pad_ctl_o.strobe_force_low : pad_ctl_o.cs_force_high, 1'b1);
        check(self_refresh_entered_o, 1'b1);
        partner_u.resume();
        wait_iso(1'b0);
        check({buffers_isolated_o, suspend_refresh_o, normal_refresh_enable_o}, 3'h1);
        check(processor_reset_out_n_o, !en);
        check(self_refresh_entered_o, 1'b0);
        if (en)
        begin
            cyc(19990);
            check(processor_reset_out_n_o, 1'b0);
            cyc(20);
            check(processor_reset_out_n_o, 1'b1);
        end
    endtask : t_susres
    task automatic t_bus_reset();
        partner_u.suspend();
        partner_u.bus_reset(1'b0);
        partner_u.resume();
        wait_iso(1'b0);
        repeat (3)
        begin
            cyc(1);
            ir_seen |= internal_reset_o;
        end
        check({buffers_isolated_o, suspend_refresh_o, normal_refresh_enable_o, ir_seen}, 4'h5);
        check(processor_reset_out_n_o, 1'b0);
        sw_normal_refresh_set_i = 1'b1;
        cyc(1);
        sw_normal_refresh_set_i = 1'b0;
        cyc(3);
        check(normal_refresh_enable_o, 1'b1);
        partner_u.suspend();
        check(buffers_isolated_o, 1'b0);
    endtask : t_bus_reset
    initial
    begin
        t_reset();
        t_susres(susres_pkg::MEM_SDRAM, 1'b0);
        t_susres(susres_pkg::MEM_EDO, 1'b1);
        t_bus_reset();
        give_verdict();
    end
    initial
    begin
        #5500000;
        error_cnt++;
        give_verdict();
    end
endmodule : suspend_resume_power_sequencer_tb
`default_nettype wire
